// *** flash_front_pkg.sv ***
/*
 * shared constants for the serial flash command front end: instruction
 * codes, command classes, phase lengths and the pin reset levels.
 * assumes an eight-bit instruction sent most significant bit first.
 */
package flash_front_pkg;

    // instruction codes recognised by the front end
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0B;
    localparam logic [7:0] OP_QUAD_READ   = 8'hEB;
    localparam logic [7:0] OP_PARAM_READ  = 8'h5A;
    localparam logic [7:0] OP_READ_ID     = 8'h9F;
    localparam logic [7:0] OP_QUAD_ID     = 8'hAF;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WAKE_ID     = 8'hAB;
    localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
    localparam logic [7:0] OP_PROGRAM     = 8'h02;
    localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE2 = 8'hC7;
    localparam logic [7:0] OP_POWER_DOWN  = 8'hB9;
    localparam logic [7:0] OP_NO_OP       = 8'h00;
    localparam logic [7:0] OP_RESET_EN    = 8'h66;
    localparam logic [7:0] OP_RESET_MEM   = 8'h99;
    localparam logic [7:0] OP_ENTER_QUAD  = 8'h35; // enter_quad_cmd
    localparam logic [7:0] OP_EXIT_QUAD   = 8'hF5; // exit_quad_cmd

    // serial clock cycles of address and dummy before data comes out
    localparam int ADDR_CYC_SINGLE = 24;
    localparam int ADDR_CYC_QUAD   = 6;
    localparam int DUMMY_FAST      = 8;
    localparam int DUMMY_QUAD_READ = 6;

    // reset levels of {select_n, sclk, quad_io_lines}
    localparam logic [5:0] PIN_RST_VAL = 6'h20;

    // how an instruction is treated once its code is known
    typedef enum logic [2:0] {
        CLS_BAD,
        CLS_RD_REG,
        CLS_RD_ARR,
        CLS_WR_REG,
        CLS_WR_ARR
    } cmd_class_t;

endpackage

// *** pin_sync.sv ***
/*
 * three-stage synchroniser for pins arriving from outside clk_sys.
 * a pin level is accepted once the second and third stage agree.
 * assumes the pins change slower than two clk_sys periods.
 */
`timescale 1ns/100ps
module pin_sync #(
    parameter int         W       = 6,
    parameter logic [5:0] RST_VAL = 6'h20
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);
    // elaboration check: the reset vector carries six pins at most
    if (W < 1 || W > 6) begin
        $error("pin_sync width out of range");
    end

    // all state of the synchroniser
    typedef struct packed {
        logic [W-1:0] st1_r;   // first stage, read by st2 only
        logic [W-1:0] st2_r;   // second stage
        logic [W-1:0] st3_r;   // third stage
        logic [W-1:0] level_r; // accepted level
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    // a bit moves only when stage two and three agree
    always_comb begin
        s_nxt       = s_r;
        s_nxt.st1_r = pin_in;
        s_nxt.st2_r = s_r.st1_r;
        s_nxt.st3_r = s_r.st2_r;
        for (int i = 0; i < W; i++) begin
            if (s_r.st2_r[i] == s_r.st3_r[i]) begin
                s_nxt.level_r[i] = s_r.st3_r[i];
            end
        end
    end

    // reset to constant pin levels only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= {4{RST_VAL[W-1:0]}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level_r;
endmodule

// *** flash_front.sv ***
/*
 * command front end of a serial nor flash: frames instructions from the
 * bus master, drives read data, reports write-type commands on release.
 * assumes clk_sys runs well above four times the serial clock.
 */
`timescale 1ns/100ps
// Operation
// RQ1 - host checks status before each instruction
// RQ2 - unknown code: standby until select rises
// RQ3 - standby keeps output pin high-impedance
// RQ4 - known code: active until select rises
// RQ5 - sample on rising, shift out falling
// RQ6 - serial modes 0 and 3 both work
// RQ7 - read types: data out, release anytime
// RQ8 - write types: release on byte boundary
// RQ9 - array access ignored while writing busy
// RQ10 - code 35h enters four-line command mode
// RQ11 - four lines everywhere, enable bit untouched
// RQ12 - code F5h returns to single-line mode
// RQ13 - quad mode uses all four data lines
// RQ14 - host waits deselect time after mode change
// RQ15 - quad instruction byte: two nibbles, high first
// RQ16 - count bits; aligned when nonzero multiple eight
module flash_front
    import flash_front_pkg::*;
#(
    parameter int LEAD_W = 6
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       select_n_pin,
    input  wire logic       sclk_pin,
    input  wire logic [3:0] quad_io_in,
    output logic      [3:0] quad_io_out,
    output logic      [3:0] quad_io_oe,
    input  wire logic       write_busy,
    input  wire logic [7:0] tx_byte,
    output logic            tx_take,
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    output logic      [7:0] cmd_code,
    output logic            cmd_start,
    output logic            cmd_exec,
    output logic            cmd_reject,
    output logic            quad_command_mode
);
    import flash_front_pkg::*;

    // elaboration check: 32 lead cycles must fit the counter
    if (LEAD_W < 6) begin
        $error("LEAD_W too small for address plus dummy");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_WR, ST_STANDBY
    } state_t;

    // all state of the front end
    typedef struct packed {
        state_t            st;      // phase of the frame
        logic              sel_r;   // previous accepted select, high active
        logic              sclk_r;  // previous accepted clock level
        logic [2:0]        bits;    // received bits modulo eight
        logic              got;     // at least one bit since select fell
        logic [7:0]        in_sh;   // input shift register
        logic              wide;    // four-line transfer in this frame
        logic [LEAD_W-1:0] lead;    // cycles left before data out
        logic [7:0]        out_sh;  // output shift register
        logic [2:0]        out_left;
        logic [3:0]        io_out;
        logic [3:0]        io_oe;
        logic [7:0]        code;
        cmd_class_t        cls;
        logic              quad;    // quad_command_mode
        logic              take;
        logic [7:0]        rx;
        logic              rxv;
        logic              start;
        logic              exec;
        logic              reject;
    } front_t;

    front_t s_r;
    front_t s_nxt;
    logic [5:0] pins;   // {select_n, sclk, quad_io_lines}

    pin_sync #(
        .W       (6),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pin_in  ({select_n_pin, sclk_pin, quad_io_in}),
        .level   (pins)
    );

    // classify a code; validity depends on the command mode
    function automatic cmd_class_t op_class(input logic [7:0] op,
                                            input logic       quad);
        case (op)
            OP_READ, OP_FAST_READ, OP_PARAM_READ:
                op_class = quad ? CLS_BAD : CLS_RD_ARR;
            OP_QUAD_READ:
                op_class = CLS_RD_ARR;
            OP_READ_ID:
                op_class = quad ? CLS_BAD : CLS_RD_REG;
            OP_QUAD_ID:
                op_class = quad ? CLS_RD_REG : CLS_BAD;
            OP_READ_STATUS, OP_WAKE_ID:
                op_class = CLS_RD_REG;
            OP_PROGRAM, OP_SECT_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE,
            OP_CHIP_ERASE2:
                op_class = CLS_WR_ARR;
            OP_WR_ENABLE, OP_WR_DISABLE, OP_POWER_DOWN, OP_NO_OP,
            OP_RESET_EN, OP_RESET_MEM:
                op_class = CLS_WR_REG;
            OP_ENTER_QUAD:
                op_class = quad ? CLS_BAD : CLS_WR_REG;
            OP_EXIT_QUAD:
                op_class = quad ? CLS_WR_REG : CLS_BAD;
            default:
                op_class = CLS_BAD;
        endcase
    endfunction

    // serial clock cycles of address plus dummy ahead of read data
    function automatic logic [LEAD_W-1:0] lead_cyc(input logic [7:0] op,
                                                   input logic       wide);
        int n;
        n = 0;
        case (op)
            OP_READ:       n = ADDR_CYC_SINGLE;
            OP_FAST_READ,
            OP_PARAM_READ: n = ADDR_CYC_SINGLE + DUMMY_FAST;
            OP_QUAD_READ:  n = (wide ? ADDR_CYC_QUAD : ADDR_CYC_SINGLE)
                               + DUMMY_QUAD_READ;
            default:       n = 0;
        endcase
        lead_cyc = n[LEAD_W-1:0];
    endfunction

    logic       sel_now;
    logic       cs_fall;
    logic       cs_rise;
    logic       rise_ev;
    logic       fall_ev;
    logic       aligned;
    logic [2:0] bits_inc;
    logic [7:0] sh_in;
    logic       byte_done;
    cmd_class_t cls_new;

    // edge detection on the accepted pin levels
    assign sel_now  = ~pins[5];
    assign cs_fall  = sel_now & ~s_r.sel_r;
    assign cs_rise  = ~sel_now & s_r.sel_r;
    assign rise_ev  = pins[4] & ~s_r.sclk_r;
    assign fall_ev  = ~pins[4] & s_r.sclk_r;
    assign aligned  = s_r.got && (s_r.bits == 3'h0);            // [RQ16]
    // four lines carry a nibble per edge, high nibble first  [RQ15][RQ13]
    assign bits_inc = s_r.bits + (s_r.wide ? 3'h4 : 3'h1);
    assign sh_in    = s_r.wide ? {s_r.in_sh[3:0], pins[3:0]}
                               : {s_r.in_sh[6:0], pins[0]};
    assign byte_done = (bits_inc == 3'h0);
    assign cls_new  = op_class(sh_in, s_r.quad);

    // next-state logic of the whole frame
    always_comb begin
        s_nxt        = s_r;
        s_nxt.sel_r  = sel_now;
        s_nxt.sclk_r = pins[4];
        s_nxt.take   = 1'b0;
        s_nxt.rxv    = 1'b0;
        s_nxt.start  = 1'b0;
        s_nxt.exec   = 1'b0;
        s_nxt.reject = 1'b0;
        if (cs_fall) begin
            // clock level at select fall is ignored: mode 0 or 3  [RQ6]
            s_nxt.st       = ST_CMD;
            s_nxt.bits     = 3'h0;
            s_nxt.got      = 1'b0;
            s_nxt.wide     = s_r.quad;                         // [RQ11]
            s_nxt.out_left = 3'h0;
            s_nxt.io_oe    = 4'h0;
        end else if (cs_rise) begin
            // write types run only on a byte-aligned release  [RQ8]
            if (s_r.st == ST_WR) begin
                if (aligned && !(s_r.cls == CLS_WR_ARR && write_busy)) begin
                    s_nxt.exec = 1'b1;
                    // mode flips; quad_enable_bit is not touched  [RQ11]
                    if (s_r.code == OP_ENTER_QUAD) begin
                        s_nxt.quad = 1'b1;                     // [RQ10]
                    end else if (s_r.code == OP_EXIT_QUAD) begin
                        s_nxt.quad = 1'b0;                     // [RQ12]
                    end
                end else begin
                    // busy array writes are dropped as well  [RQ9]
                    s_nxt.reject = 1'b1;
                end
            end
            // a read may end after any output bit  [RQ7]
            s_nxt.st    = ST_IDLE;
            s_nxt.io_oe = 4'h0;
        end else if (sel_now && rise_ev && (s_r.st == ST_CMD ||
                     s_r.st == ST_ADDR || s_r.st == ST_WR)) begin
            // inputs are taken on the rising clock edge  [RQ5]
            s_nxt.in_sh = sh_in;
            s_nxt.bits  = bits_inc;
            s_nxt.got   = 1'b1;
            if (s_r.st == ST_CMD) begin
                if (byte_done) begin
                    s_nxt.code = sh_in;
                    s_nxt.cls  = cls_new;
                    if (cls_new == CLS_BAD ||
                        (cls_new == CLS_RD_ARR && write_busy)) begin
                        s_nxt.st = ST_STANDBY;             // [RQ2][RQ9]
                    end else begin
                        // a known code holds the frame active  [RQ4]
                        s_nxt.start = 1'b1;
                        if (sh_in == OP_QUAD_READ) begin
                            s_nxt.wide = 1'b1;
                        end
                        if (cls_new == CLS_WR_REG ||
                            cls_new == CLS_WR_ARR) begin
                            s_nxt.st = ST_WR;
                        end else begin
                            // eb takes a four-line address in either mode
                            s_nxt.lead = lead_cyc(sh_in, s_nxt.wide);
                            s_nxt.st   = (lead_cyc(sh_in, s_nxt.wide) == '0)
                                         ? ST_DATA : ST_ADDR;  // [RQ7]
                        end
                    end
                end
            end else begin
                // address and payload bytes go to the user side
                if (byte_done) begin
                    s_nxt.rx  = sh_in;
                    s_nxt.rxv = 1'b1;
                end
                if (s_r.st == ST_ADDR) begin
                    s_nxt.lead = s_r.lead - 1'b1;
                    if (s_r.lead == 1) begin
                        s_nxt.st = ST_DATA;
                    end
                end
            end
        end else if (sel_now && fall_ev && s_r.st == ST_DATA) begin
            // outputs move on the falling clock edge  [RQ5]
            if (s_r.out_left == 3'h0) begin
                s_nxt.out_sh   = tx_byte;
                s_nxt.take     = 1'b1;
                s_nxt.out_left = s_r.wide ? 3'h1 : 3'h7;
            end else begin
                s_nxt.out_sh   = s_r.wide ? {s_r.out_sh[3:0], 4'h0}
                                          : {s_r.out_sh[6:0], 1'b0};
                s_nxt.out_left = s_r.out_left - 1'b1;
            end
            // quad drives all four lines, single only the output line
            if (s_r.wide) begin
                s_nxt.io_out = s_nxt.out_sh[7:4];              // [RQ13]
                s_nxt.io_oe  = 4'hF;
            end else begin
                s_nxt.io_out = {2'b00, s_nxt.out_sh[7], 1'b0};
                s_nxt.io_oe  = 4'h2;
            end
        end
        // standby never drives the lines  [RQ3]
        if (s_nxt.st == ST_STANDBY || s_nxt.st == ST_IDLE) begin
            s_nxt.io_oe = 4'h0;
        end
    end

    // state register; constants only under reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: ST_IDLE, cls: CLS_BAD, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign quad_io_out       = s_r.io_out;
    assign quad_io_oe        = s_r.io_oe;
    assign tx_take           = s_r.take;
    assign rx_byte           = s_r.rx;
    assign rx_valid          = s_r.rxv;
    assign cmd_code          = s_r.code;
    assign cmd_start         = s_r.start;
    assign cmd_exec          = s_r.exec;
    assign cmd_reject        = s_r.reject;
    assign quad_command_mode = s_r.quad;

    // checks on the frame behaviour
    sequence s_bad_code;
        s_r.st == ST_CMD && sel_now && !cs_rise && !cs_fall && rise_ev &&
        byte_done && cls_new == CLS_BAD;
    endsequence

    sequence s_good_code;
        s_r.st == ST_CMD && sel_now && !cs_rise && !cs_fall && rise_ev &&
        byte_done && cls_new != CLS_BAD && !write_busy;
    endsequence

    property p_standby_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        s_r.st == ST_STANDBY |-> quad_io_oe == 4'h0;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) // [RQ3]
        else $error("lines driven in standby");

    property p_bad_to_standby;
        @(posedge clk_sys) disable iff (!rstn)
        s_bad_code |=> s_r.st == ST_STANDBY && !cmd_start;
    endproperty
    a_bad_to_standby: assert property (p_bad_to_standby) // [RQ2]
        else $error("unknown code did not enter standby");

    property p_good_active;
        @(posedge clk_sys) disable iff (!rstn)
        s_good_code |=> cmd_start && s_r.st != ST_STANDBY
                        && s_r.st != ST_IDLE;
    endproperty
    a_good_active: assert property (p_good_active) // [RQ4]
        else $error("known code not taken");

    property p_out_on_fall;
        @(posedge clk_sys) disable iff (!rstn)
        $changed(quad_io_out) |-> $past(fall_ev);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) // [RQ5]
        else $error("output moved away from falling clock");

    property p_exec_aligned;
        @(posedge clk_sys) disable iff (!rstn)
        cmd_exec |-> $past(aligned) && $past(cs_rise) && !cmd_reject;
    endproperty
    a_exec_aligned: assert property (p_exec_aligned) // [RQ8][RQ16]
        else $error("write executed off byte boundary");

    property p_busy_array_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_r.st == ST_CMD && sel_now && !cs_rise && rise_ev && byte_done
        && cls_new == CLS_RD_ARR && write_busy |=> s_r.st == ST_STANDBY;
    endproperty
    a_busy_array_read: assert property (p_busy_array_read) // [RQ9]
        else $error("array read accepted while busy");

    property p_enter_quad;
        @(posedge clk_sys) disable iff (!rstn)
        cmd_exec && cmd_code == OP_ENTER_QUAD |-> quad_command_mode
        ##1 quad_command_mode;
    endproperty
    a_enter_quad: assert property (p_enter_quad) // [RQ10]
        else $error("enter code did not set quad mode");

    property p_exit_quad;
        @(posedge clk_sys) disable iff (!rstn)
        cmd_exec && cmd_code == OP_EXIT_QUAD |-> !quad_command_mode;
    endproperty
    a_exit_quad: assert property (p_exit_quad) // [RQ12]
        else $error("exit code did not clear quad mode");

    property p_release_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_r.st == ST_DATA && cs_rise |=> quad_io_oe == 4'h0
        && !cmd_reject ##1 quad_io_oe == 4'h0;
    endproperty
    a_release_read: assert property (p_release_read) // [RQ7][RQ3]
        else $error("read release not clean");

    property p_quad_lines;
        @(posedge clk_sys) disable iff (!rstn)
        s_r.st == ST_DATA && quad_command_mode && quad_io_oe != 4'h0
        |-> quad_io_oe == 4'hF;
    endproperty
    a_quad_lines: assert property (p_quad_lines) // [RQ13][RQ11]
        else $error("quad data not on four lines");
endmodule

// *** flash_host_model.sv ***
/*
 * behavioural bus master that faces the flash front end's pins.
 * assumes the bench changes mode3 and quad only between frames.
 */
`timescale 1ns/100ps
module flash_host_model #(
    parameter real HALF_NS  = 200.0, // half of the 400 ns link clock
    parameter real DESEL_NS = 800.0  // deselect_min_time, plain default
) (
    input  wire logic       mode3,
    input  wire logic       quad,
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe,
    output logic            select_n,
    output logic            sclk,
    output logic      [3:0] io_wire
);
    logic [3:0] host_val; // last level the master put on each line
    logic [3:0] host_oe;  // master drive enables

    // resolve lines; a released line shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_wire[i] = (dev_oe[i] === 1'b1) ? dev_out[i]
                       : (host_oe[i] ? host_val[i] : ~host_val[i]);
        end
    end

    // deselected and idle at time zero
    initial begin
        select_n = 1'b1;
        sclk     = 1'b0;
        host_val = 4'h0;
        host_oe  = 4'h0;
    end

    // one frame: n_drv cycles driven from tx, n_cyc cycles in total
    task automatic frame(input int n_drv, input int n_cyc,
                         input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        sclk = mode3; // idle low for mode 0, high for mode 3
        #(HALF_NS + 13.0);
        select_n = 1'b0;
        #(HALF_NS);
        for (int c = 0; c < n_cyc; c++) begin
            sclk = 1'b0; // device shifts out on this fall
            host_oe = (c < n_drv) ? (quad ? 4'hF : 4'h1) : 4'h0;
            if (c < n_drv) begin
                host_val = quad ? tx[63:60] : {host_val[3:1], tx[63]};
                tx = quad ? (tx << 4) : (tx << 1);
            end
            #(HALF_NS);
            sclk = 1'b1; // device samples on this rise
            #(HALF_NS);
            // sampled late: the pin synchroniser delays the device output
            rx = quad ? {rx[59:0], io_wire} : {rx[62:0], io_wire[1]};
        end
        if (!mode3) begin
            sclk = 1'b0;
            #(HALF_NS);
        end
        select_n = 1'b1;
        host_oe = 4'h0;
        #(DESEL_NS); // deselect gap, also after mode changes
    endtask
endmodule

// *** flash_front_tb.sv ***
/*
 * self-checking bench for flash_front driven by a behavioural master.
 * assumes flash_host_model and the package constants are compiled.
 */
`timescale 1ns/100ps
module flash_front_tb;
    import flash_front_pkg::*;

    logic        clk_sys, rstn, mode3, quad, write_busy;
    logic        select_n_pin, sclk_pin, tx_take, rx_valid;
    logic        cmd_start, cmd_exec, cmd_reject, quad_command_mode;
    logic [3:0]  quad_io_in, quad_io_out, quad_io_oe, oe_seen;
    logic [7:0]  tx_byte, rx_byte, cmd_code, last_rx, op;
    logic [31:0] seed;
    logic [63:0] rx, pw; // sampled bits (newest lowest), program word
    int          err_total, num_checks, n_start, n_exec, n_rej, n_rx, n_take;
    logic [7:0]  wr_ops [8] = '{OP_WR_ENABLE, OP_WR_DISABLE, OP_CHIP_ERASE,
        OP_CHIP_ERASE2, OP_NO_OP, OP_RESET_EN, OP_RESET_MEM, OP_POWER_DOWN};

    flash_front uut (
        .clk_sys(clk_sys), .rstn(rstn), .select_n_pin(select_n_pin),
        .sclk_pin(sclk_pin), .quad_io_in(quad_io_in),
        .quad_io_out(quad_io_out), .quad_io_oe(quad_io_oe),
        .write_busy(write_busy), .tx_byte(tx_byte), .tx_take(tx_take),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .cmd_code(cmd_code),
        .cmd_start(cmd_start), .cmd_exec(cmd_exec), .cmd_reject(cmd_reject),
        .quad_command_mode(quad_command_mode)
    );

    flash_host_model host (
        .mode3(mode3), .quad(quad), .dev_out(quad_io_out),
        .dev_oe(quad_io_oe), .select_n(select_n_pin), .sclk(sclk_pin),
        .io_wire(quad_io_in)
    );

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // xorshift source of the random values
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // codes the front end accepts in single-line command mode
    function automatic bit known_single(input logic [7:0] c);
        case (c)
            OP_READ, OP_FAST_READ, OP_QUAD_READ, OP_PARAM_READ, OP_READ_ID,
            OP_READ_STATUS, OP_WAKE_ID, OP_WR_ENABLE, OP_WR_DISABLE,
            OP_PROGRAM, OP_SECT_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE,
            OP_CHIP_ERASE2, OP_POWER_DOWN, OP_NO_OP, OP_RESET_EN,
            OP_RESET_MEM, OP_ENTER_QUAD: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // tallies of pulses and output enables since the last clear
    always @(posedge clk_sys) begin
        if (cmd_start === 1'b1) n_start <= n_start + 1;
        if (cmd_exec === 1'b1) n_exec <= n_exec + 1;
        if (cmd_reject === 1'b1) n_rej <= n_rej + 1;
        if (tx_take === 1'b1) n_take <= n_take + 1;
        if (rx_valid === 1'b1) begin
            n_rx <= n_rx + 1;
            last_rx <= rx_byte;
        end
        oe_seen <= oe_seen | quad_io_oe;
    end

    // one frame, then the pulse counts it must have produced
    task automatic run(input int n_drv, input int n_cyc,
                       input logic [63:0] tx, input int e_start,
                       input int e_exec, input int e_rej);
        @(posedge clk_sys) #2 {n_start, n_exec, n_rej, n_rx, n_take} = 160'h0;
        oe_seen = 4'h0;
        host.frame(n_drv, n_cyc, tx, rx);
        chk("cmd_start count", e_start, n_start);
        chk("cmd_exec count", e_exec, n_exec);
        chk("cmd_reject count", e_rej, n_rej);
    endtask

    // hang guard; a frame sequence has no open wait of its own
    initial begin
        #3000000;
        err_total++;
        $display("CHECK FAILED run time expected end seen limit reached");
        stop_test();
    end

    initial begin
        {rstn, mode3, quad, write_busy} = 4'h0;
        tx_byte = 8'h00;
        seed = 32'h49D2;
        repeat (20) @(posedge clk_sys);
        #2 rstn = 1'b1;
        chk("oe after reset", 4'h0, quad_io_oe);
        repeat (6) @(posedge clk_sys);
        for (int m = 0; m < 2; m++) begin
            seed = next_rand(seed);
            @(posedge clk_sys) #2 tx_byte = seed[7:0];
            mode3 = m[0];
            run(8, 24, {OP_READ_STATUS, 56'h0}, 1, 0, 0);
            chk("status data", {tx_byte, tx_byte}, rx[15:0]);
            // two full bytes; mode 0 ends on one more fall, a third load
            chk("tx_take count", 3 - m, n_take);
            chk("single oe", 4'h2, oe_seen);
            chk("oe after release", 4'h0, quad_io_oe);
            run(8, 11, {OP_READ_STATUS, 56'h0}, 1, 0, 0);
        end
        end_test("status reads");
        foreach (wr_ops[i]) begin
            mode3 = i[0];
            run(8, 8, {wr_ops[i], 56'h0}, 1, 1, 0);
            chk("cmd_code", wr_ops[i], cmd_code);
        end
        run(8, 40, {OP_WAKE_ID, 56'h0}, 1, 0, 0);
        run(8, 11, {OP_WR_ENABLE, 56'h0}, 1, 0, 1);
        run(8, 16, {OP_WR_ENABLE, 56'h0}, 1, 1, 0);
        run(5, 5, {OP_WR_ENABLE, 56'h0}, 0, 0, 0);
        end_test("write types");
        for (int k = 0; k < 6; k++) begin
            do
                seed = next_rand(seed);
            while (known_single(seed[7:0]));
            op = (k == 0) ? OP_EXIT_QUAD : (k == 1) ? OP_QUAD_ID : seed[7:0];
            run(16, 24, {op, seed[15:8], 48'h0}, 0, 0, 0);
            chk("standby oe", 4'h0, oe_seen);
        end
        run(8, 8, {OP_WR_ENABLE, 56'h0}, 1, 1, 0);
        end_test("unknown codes");
        seed = next_rand(seed);
        pw = {OP_PROGRAM, seed[23:0], seed[31:24], 24'h0};
        @(posedge clk_sys) #2 write_busy = 1'b1;
        run(40, 40, pw, 1, 0, 1);
        run(32, 48, {OP_READ, seed[23:0], 32'h0}, 0, 0, 0);
        chk("busy read oe", 4'h0, oe_seen);
        @(posedge clk_sys) #2 write_busy = 1'b0;
        run(32, 48, {OP_READ, seed[23:0], 32'h0}, 1, 0, 0);
        chk("address bytes", 3, n_rx);
        chk("last address byte", seed[7:0], last_rx);
        chk("array data", {tx_byte, tx_byte}, rx[15:0]);
        run(40, 40, pw, 1, 1, 0);
        end_test("busy array");
        mode3 = 1'b0;
        run(8, 8, {OP_ENTER_QUAD, 56'h0}, 1, 1, 0);
        chk("quad mode on", 1, quad_command_mode);
        quad = 1'b1;
        run(2, 2, {OP_WR_ENABLE, 56'h0}, 1, 1, 0);
        chk("quad cmd_code", OP_WR_ENABLE, cmd_code);
        run(2, 6, {OP_READ_STATUS, 56'h0}, 1, 0, 0);
        chk("quad status", {tx_byte, tx_byte}, rx[15:0]);
        chk("quad oe", 4'hF, oe_seen);
        run(10, 10, pw, 1, 1, 0);
        chk("quad payload", seed[31:24], last_rx);
        run(8, 18, {OP_QUAD_READ, seed[23:0], 32'h0}, 1, 0, 0);
        chk("quad read data", {tx_byte, tx_byte}, rx[15:0]);
        chk("quad read bytes", 6, n_rx);
        run(2, 2, {OP_ENTER_QUAD, 56'h0}, 0, 0, 0);
        run(2, 2, {OP_EXIT_QUAD, 56'h0}, 1, 1, 0);
        chk("quad mode off", 0, quad_command_mode);
        quad = 1'b0;
        run(8, 8, {OP_WR_ENABLE, 56'h0}, 1, 1, 0);
        end_test("quad mode");
        stop_test();
    end
endmodule
